//--- pkg/sdpr_pkg.sv
// Purpose: Constants for the SDRAM precharge and refresh timing block
// Assumes: Single clock at 125 MHz, four banks, DDR command/address bus
// Notes:   Timing figures in ps, cycle counts derived from the clock period
package sdpr_pkg;
    localparam int CLK_PERIOD_PS = 8000;
    localparam int NUM_BANKS     = 4;
    localparam int BANK_W        = 2;
    localparam int CA_W          = 10;
    localparam int CNT_W         = 12;

    // Write latency in clocks, burst length and prefetch in words
    localparam int WL_CLK = 1;
    localparam int BL     = 4;
    localparam int PREFETCH = 4;

    // Analog times in ps, as printed in ns times 1000
    localparam int T_WR_PS     = 15000;
    localparam int T_RTP_PS    = 7500;
    localparam int T_RP_PS     = 18000;
    localparam int T_RFCAB_PS  = 130000;

    // Least times round up
    localparam int T_WR_CLK    = (T_WR_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int T_RTP_CLK   = (T_RTP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int T_RP_CLK    = (T_RP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int T_RFCAB_CLK = (T_RFCAB_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Command decode bit positions, CA_AP on the falling-edge word, the rest on the rising-edge word
    localparam int CA_CMD0 = 0;
    localparam int CA_CMD1 = 1;
    localparam int CA_CMD2 = 2;
    localparam int CA_CMD3 = 3;
    localparam int CA_AB   = 4;
    localparam int CA_BA0  = 7;
    localparam int CA_BA1  = 8;
    localparam int CA_AP   = 0;
    localparam int CA_WR   = 2;

    typedef enum logic [1:0] {
        SDPR_BANK_IDLE,
        SDPR_BANK_ACTIVE,
        SDPR_BANK_PRECHARGING
    } sdpr_bank_state_t;
endpackage

//--- logic/sdpr_timing.sv
// Purpose: Device-side command decode, auto-precharge and refresh timing
// Assumes: Command pins already aligned to i_clk_sys, ca_r rising, ca_f falling
// Notes:   Bank state and timers in flip-flops, no registers for software
// Behaviour
// [RULE1] Controller waits write recovery after last write data before precharge.
// [RULE2] Write to precharge spacing at least WL + BL/2 + 1 + tWR clocks.
// [RULE3] Array write starts on a four-word prefetch boundary, recovery follows it.
// [RULE4] AP bit on falling-edge CA0 selects auto-precharge for read and write.
// [RULE5] Read auto-precharge starts max(BL/2, BL/2 - 2 + tRTP) after command.
// [RULE6] Write auto-precharge starts tWR cycles after the burst write completes.
// [RULE7] Activate after auto-precharge waits tRP and tRC.
// [RULE8] Read to precharge waits BL/2 + max(2, tRTP) - 2 clocks.
// [RULE9] Read burst terminate to precharge at least one clock.
// [RULE10] Read AP to activate waits read-precharge delay plus tRPpb.
// [RULE11] After read AP no write same bank; other bank needs long gap.
// [RULE12] After read AP no read same bank; other bank after BL/2.
// [RULE13] Write burst terminate to precharge waits WL + tWR + 1.
// [RULE14] Write AP to activate waits write-precharge delay plus tRPpb.
// [RULE15] After write AP no access same bank; other banks have gaps.
// [RULE16] Any two precharges at least one clock apart.
// [RULE17] Precharge period runs tRP from the latest precharge to the bank.
// [RULE18] Commands inside minimum delay windows are illegal.
// [RULE19] Auto-precharge reads and writes are never interrupted or truncated.
// [RULE20] Refresh decodes as CS_n low, CA0 low, CA1 low, CA2 high; CA3 low per-bank.
// [RULE21] All-bank refresh needs idle banks, zeroes bank counter, leaves banks idle.
// [RULE22] All-bank refresh spacing tRFCab and tRP; tRFCab before activate.
// [RULE23] Precharge decode CS_n low, 1,1,0,1; CA4 all banks else BA bits.
// [RULE24] Truncated burst length is twice clocks from command to terminate.
// [RULE25] CA3 high on refresh selects all-bank refresh.
`timescale 1ns/1ps
`default_nettype none
module sdpr_timing (
    input  wire logic                         i_clk_sys,
    input  wire logic                         i_rst_n,
    input  wire logic                         i_ce,
    input  wire logic                         i_cs_n,
    input  wire logic [sdpr_pkg::CA_W-1:0]    i_ca_r,
    input  wire logic [sdpr_pkg::CA_W-1:0]    i_ca_f,
    output logic      [sdpr_pkg::NUM_BANKS-1:0] o_bank_open,
    output logic      [sdpr_pkg::NUM_BANKS-1:0] o_bank_precharging,
    output logic                              o_refresh_busy,
    output logic      [sdpr_pkg::BANK_W-1:0]  o_bank_count,
    output logic                              o_cmd_illegal
);
    localparam logic [sdpr_pkg::CNT_W-1:0] RD_AP_DLY =
        sdpr_pkg::CNT_W'((sdpr_pkg::BL/2 > sdpr_pkg::BL/2 - 2 + sdpr_pkg::T_RTP_CLK)
        ? sdpr_pkg::BL/2 : sdpr_pkg::BL/2 - 2 + sdpr_pkg::T_RTP_CLK);
    localparam logic [sdpr_pkg::CNT_W-1:0] TRP_CNT = sdpr_pkg::CNT_W'(sdpr_pkg::T_RP_CLK);
    localparam logic [sdpr_pkg::CNT_W-1:0] TRFC_CNT =
        sdpr_pkg::CNT_W'(sdpr_pkg::T_RFCAB_CLK);

    // [RULE24] Burst length argument
    // Write AP delay, burst end rounded up to a prefetch group, then tWR
    function automatic logic [sdpr_pkg::CNT_W-1:0] wr_ap_delay(input int bl);
        int words;
        words = ((bl + sdpr_pkg::PREFETCH - 1) / sdpr_pkg::PREFETCH) * sdpr_pkg::PREFETCH;
        return sdpr_pkg::CNT_W'(sdpr_pkg::WL_CLK + words / 2 + 1 + sdpr_pkg::T_WR_CLK);
    endfunction

    function automatic logic is_cmd(input logic [3:0] pat, input logic [3:0] cmd);
        return pat == cmd;
    endfunction

    sdpr_pkg::sdpr_bank_state_t             state_reg [sdpr_pkg::NUM_BANKS];
    sdpr_pkg::sdpr_bank_state_t             state_next[sdpr_pkg::NUM_BANKS];
    logic [sdpr_pkg::CNT_W-1:0]             tmr_reg [sdpr_pkg::NUM_BANKS];
    logic [sdpr_pkg::CNT_W-1:0]             tmr_next[sdpr_pkg::NUM_BANKS];
    logic [sdpr_pkg::NUM_BANKS-1:0]         ap_pend_reg;
    logic [sdpr_pkg::NUM_BANKS-1:0]         ap_pend_next;
    logic [sdpr_pkg::CNT_W-1:0]             rfc_reg;
    logic [sdpr_pkg::CNT_W-1:0]             rfc_next;
    logic [sdpr_pkg::BANK_W-1:0]            bcnt_reg;
    logic [sdpr_pkg::BANK_W-1:0]            bcnt_next;
    logic                                   ill_reg;
    logic                                   ill_next;
    logic                                   pre_last_reg;
    logic                                   pre_last_next;

    logic [3:0]                  pat;
    logic [sdpr_pkg::BANK_W-1:0] ba;
    logic                        c_pre;
    logic                        c_ref;
    logic                        c_act;
    logic                        c_rw;
    logic                        c_bst;
    logic                        all_idle;

    always_comb begin
        pat = {i_ca_r[sdpr_pkg::CA_CMD3], i_ca_r[sdpr_pkg::CA_CMD2],
               i_ca_r[sdpr_pkg::CA_CMD1], i_ca_r[sdpr_pkg::CA_CMD0]};
        ba  = {i_ca_r[sdpr_pkg::CA_BA1], i_ca_r[sdpr_pkg::CA_BA0]};
        // [RULE23] Precharge decode
        c_pre = !i_cs_n && is_cmd(pat, 4'hB);
        c_bst = !i_cs_n && is_cmd(pat, 4'h3);
        // [RULE20] Refresh decode
        c_ref = !i_cs_n && !pat[0] && !pat[1] && pat[2];
        c_act = !i_cs_n && !pat[0] && pat[1];
        c_rw  = !i_cs_n && pat[0] && !pat[1];
    end

    always_comb begin
        all_idle = 1'b1;
        for (int b = 0; b < sdpr_pkg::NUM_BANKS; b++) begin
            if (state_reg[b] != sdpr_pkg::SDPR_BANK_IDLE) begin
                all_idle = 1'b0;
            end
        end
    end

    always_comb begin
        rfc_next      = (rfc_reg != '0) ? rfc_reg - 1'b1 : rfc_reg;
        bcnt_next     = bcnt_reg;
        ill_next      = 1'b0;
        pre_last_next = c_pre;
        ap_pend_next  = ap_pend_reg;
        for (int b = 0; b < sdpr_pkg::NUM_BANKS; b++) begin
            state_next[b] = state_reg[b];
            tmr_next[b]   = (tmr_reg[b] != '0) ? tmr_reg[b] - 1'b1 : tmr_reg[b];
            // [RULE17] Precharge period ends after tRP
            if (state_reg[b] == sdpr_pkg::SDPR_BANK_PRECHARGING && tmr_reg[b] <= 1) begin
                state_next[b] = sdpr_pkg::SDPR_BANK_IDLE;
                tmr_next[b]   = '0;
            end
            // [RULE5] Auto-precharge start on timer expiry
            if (ap_pend_reg[b] && tmr_reg[b] <= 1) begin
                ap_pend_next[b] = 1'b0;
                state_next[b]   = sdpr_pkg::SDPR_BANK_PRECHARGING;
                tmr_next[b]     = TRP_CNT;
            end
        end
        if (i_ce) begin
            // [RULE16] Back-to-back precharge flagged
            if (c_pre && pre_last_reg) begin
                ill_next = 1'b1;
            end
            for (int b = 0; b < sdpr_pkg::NUM_BANKS; b++) begin
                // [RULE17] Latest precharge restarts tRP
                if (c_pre && (i_ca_r[sdpr_pkg::CA_AB] || ba == sdpr_pkg::BANK_W'(b))
                    && !ap_pend_reg[b] && state_reg[b] != sdpr_pkg::SDPR_BANK_IDLE) begin
                    state_next[b] = sdpr_pkg::SDPR_BANK_PRECHARGING;
                    tmr_next[b]   = TRP_CNT;
                end
            end
            if (c_act) begin
                // [RULE22] Activate inside tRFCab is illegal
                if (rfc_reg != '0 || state_reg[ba] != sdpr_pkg::SDPR_BANK_IDLE) begin
                    ill_next = 1'b1;
                end else begin
                    state_next[ba] = sdpr_pkg::SDPR_BANK_ACTIVE;
                end
            end
            if (c_rw) begin
                // [RULE15] Access to a bank with pending auto-precharge
                if (ap_pend_reg[ba] || state_reg[ba] != sdpr_pkg::SDPR_BANK_ACTIVE) begin
                    ill_next = 1'b1;
                // [RULE4] AP bit on falling edge
                end else if (i_ca_f[sdpr_pkg::CA_AP]) begin
                    ap_pend_next[ba] = 1'b1;
                    // [RULE6] Write recovery from prefetch-aligned burst end
                    // [RULE3] Prefetch group alignment
                    tmr_next[ba] = i_ca_r[sdpr_pkg::CA_WR] ? wr_ap_delay(sdpr_pkg::BL)
                                                           : RD_AP_DLY;
                end
            end
            // [RULE19] Terminate during an auto-precharge burst
            if (c_bst && ap_pend_reg != '0) begin
                ill_next = 1'b1;
            end
            // [RULE25] All-bank refresh on CA3 high
            if (c_ref && pat[3]) begin
                // [RULE21] Banks must be idle
                if (!all_idle || rfc_reg != '0) begin
                    ill_next = 1'b1;
                end else begin
                    bcnt_next = '0;
                    rfc_next  = TRFC_CNT;
                end
            // [RULE20] Per-bank refresh on CA3 low
            end else if (c_ref) begin
                // [RULE21] Shared counter advances
                bcnt_next = bcnt_reg + 1'h1;
            end

        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int b = 0; b < sdpr_pkg::NUM_BANKS; b++) begin
                state_reg[b] <= sdpr_pkg::SDPR_BANK_IDLE;
                tmr_reg[b]   <= '0;
            end
            ap_pend_reg  <= '0;
            rfc_reg      <= '0;
            bcnt_reg     <= '0;
            ill_reg      <= 1'b0;
            pre_last_reg <= 1'b0;
        end else if (i_ce) begin
            for (int b = 0; b < sdpr_pkg::NUM_BANKS; b++) begin
                state_reg[b] <= state_next[b];
                tmr_reg[b]   <= tmr_next[b];
            end
            ap_pend_reg  <= ap_pend_next;
            rfc_reg      <= rfc_next;
            bcnt_reg     <= bcnt_next;
            ill_reg      <= ill_next;
            pre_last_reg <= pre_last_next;
        end
    end

    always_comb begin
        for (int b = 0; b < sdpr_pkg::NUM_BANKS; b++) begin
            o_bank_open[b]        = state_reg[b] == sdpr_pkg::SDPR_BANK_ACTIVE;
            o_bank_precharging[b] = state_reg[b] == sdpr_pkg::SDPR_BANK_PRECHARGING;
        end
    end

    assign o_refresh_busy = rfc_reg != '0;
    assign o_bank_count   = bcnt_reg;
    assign o_cmd_illegal  = ill_reg;
endmodule
`default_nettype wire

//--- verification/sdpr_timing_chk_sva.sv
// Purpose: Assertions for the precharge and refresh timing block
// Assumes: Bound to sdpr_timing from tb_top
// Notes:   Bank 0 stands for every bank
`timescale 1ns/1ps
`default_nettype none
module sdpr_timing_chk (
    input wire logic       i_clk_sys,
    input wire logic       i_rst_n,
    input wire logic       i_ce,
    input wire logic       i_cs_n,
    input wire logic [9:0] i_ca_r,
    input wire logic [9:0] i_ca_f,
    input wire logic [3:0] o_bank_open,
    input wire logic [3:0] o_bank_precharging,
    input wire logic       o_refresh_busy,
    input wire logic [1:0] o_bank_count,
    input wire logic       o_cmd_illegal
);
    logic       take;
    logic       b0;
    logic [4:0] busy_cnt_reg;
    logic [4:0] busy_cnt_next;
    assign take = i_ce && !i_cs_n;
    assign b0 = take && i_ca_r[8:7] == 2'h0 && o_bank_open[0];
    assign busy_cnt_next = o_refresh_busy ? busy_cnt_reg + 5'h01 : 5'h00;
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) busy_cnt_reg <= 5'h00;
        else if (i_ce) busy_cnt_reg <= busy_cnt_next;
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    prech_all_a: assert property (
        take && i_ca_r[4:0] == 5'h1B |-> ##[1:2] o_bank_open == 4'h0) else $error("bank stays open");
    ref_start_a: assert property (
        take && i_ca_r[3:0] == 4'hC && !o_refresh_busy && o_bank_open == 4'h0
        && o_bank_precharging == 4'h0 |-> ##[1:2] (o_refresh_busy && o_bank_count == 2'h0))
        else $error("refresh did not start");
    ref_len_a: assert property ($fell(o_refresh_busy) |-> busy_cnt_reg == 5'h11)
        else $error("refresh busy length wrong");
    ref_idle_a: assert property (o_refresh_busy |-> o_bank_open == 4'h0)
        else $error("bank open during refresh");
    prech_len_a: assert property (
        $rose(o_bank_precharging[0]) |-> o_bank_precharging[0] [*3]) else $error("short precharge");
    rd_ap_a: assert property (
        b0 && i_ca_r[2:0] == 3'h1 && i_ca_f[0]
        |-> ##1 !o_bank_precharging[0] ##[1:2] o_bank_precharging[0]) else $error("read ap timing");
    wr_ap_a: assert property (
        b0 && i_ca_r[2:0] == 3'h5 && i_ca_f[0]
        |-> ##1 (!o_bank_precharging[0]) [*4] ##[1:3] o_bank_precharging[0])
        else $error("write ap timing");
    no_ap_a: assert property (
        b0 && i_ca_r[1:0] == 2'h1 && !i_ca_f[0] ##1 i_cs_n [*6]
        |-> o_bank_open[0] && !o_bank_precharging[0]) else $error("bank closed without ap");
    b2b_prech_a: assert property (
        take && i_ca_r[3:0] == 4'hB ##1 take && i_ca_r[3:0] == 4'hB |-> ##[1:2] o_cmd_illegal)
        else $error("back to back precharge accepted");
    cover property (o_refresh_busy);
    cover property (o_cmd_illegal);
    cover property ($rose(o_bank_precharging[0]));
    cover property (o_bank_count != 2'h0);
endmodule
`default_nettype wire

//--- verification/sdpr_ctrl_model.sv
// Purpose: Controller model issuing commands on chip select and CA
// Assumes: Bench calls issue once per command, or once per run of one repeated command
// Notes:   Idle CA lines carry the inverse of the last word
`timescale 1ns/1ps
`default_nettype none
module sdpr_ctrl_model (
    input  wire logic       i_clk_sys,
    output var  logic       o_cs_n,
    output var  logic [9:0] o_ca_r,
    output var  logic [9:0] o_ca_f
);
    initial begin
        o_cs_n = 1'b1;
        o_ca_r = 10'h000;
        o_ca_f = 10'h000;
    end
    task automatic issue(input logic [9:0] r, input logic [9:0] f, input logic go,
                         input logic [1:0] n);
        repeat (n) begin
            @(posedge i_clk_sys);
            o_cs_n <= !go;
            o_ca_r <= r;
            o_ca_f <= f;
        end
        @(posedge i_clk_sys);
        o_cs_n <= 1'b1;
        o_ca_r <= ~r;
        o_ca_f <= ~f;
    endtask
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// Purpose: Self-checking bench for the precharge and refresh timing block
// Assumes: Controller model drives the command pins
// Notes:   Table rows first, then back-to-back, refused refresh and reset
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct {logic [9:0] r; logic [9:0] f; logic go; logic [4:0] w;
                    logic [10:0] exp; logic [4:0] ill;} sdpr_row_t;
    logic       i_clk_sys;
    logic       i_rst_n;
    logic       ce;
    logic       cs_n;
    logic [9:0] ca_r;
    logic [9:0] ca_f;
    logic [3:0] bank_open;
    logic [3:0] bank_prech;
    logic       ref_busy;
    logic [1:0] bank_count;
    logic       cmd_illegal;
    int         err_count = 0;
    int         num_checks = 0;
    int         ill_count = 0;
    sdpr_row_t  rows [19];
    sdpr_timing u_sdpr_timing (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_ce(ce), .i_cs_n(cs_n),
        .i_ca_r(ca_r), .i_ca_f(ca_f), .o_bank_open(bank_open), .o_bank_precharging(bank_prech),
        .o_refresh_busy(ref_busy), .o_bank_count(bank_count), .o_cmd_illegal(cmd_illegal));
    sdpr_ctrl_model u_sdpr_ctrl_model (.i_clk_sys(i_clk_sys), .o_cs_n(cs_n), .o_ca_r(ca_r),
        .o_ca_f(ca_f));
    always #4 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) if (cmd_illegal === 1'b1) ill_count <= ill_count + 1;
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic probe(input logic [10:0] exp, input logic [4:0] ill);
        @(negedge i_clk_sys);
        check({5'h00, bank_open, bank_prech, ref_busy, bank_count}, {5'h00, exp});
        check(16'(ill_count), {11'h000, ill});
    endtask
    task automatic cmd(input logic [9:0] r, input logic [1:0] n);
        u_sdpr_ctrl_model.issue(r, 10'h000, 1'h1, n);
    endtask
    initial begin
        repeat (1000) @(posedge i_clk_sys);
        err_count++;
        complete_run();
    end
    initial begin
        i_clk_sys = 1'b0;
        i_rst_n = 1'b0;
        ce = 1'b1;
        rows = '{'{10'h001, 10'h000, 1'h1, 5'h02, 11'h000, 5'h01},
            '{10'h002, 10'h000, 1'h1, 5'h02, 11'h080, 5'h01},
            '{10'h001, 10'h000, 1'h1, 5'h07, 11'h080, 5'h01},
            '{10'h001, 10'h001, 1'h1, 5'h04, 11'h008, 5'h01},
            '{10'h000, 10'h000, 1'h0, 5'h06, 11'h000, 5'h01},
            '{10'h002, 10'h000, 1'h1, 5'h02, 11'h080, 5'h01},
            '{10'h005, 10'h001, 1'h1, 5'h02, 11'h080, 5'h01},
            '{10'h003, 10'h000, 1'h1, 5'h03, 11'h008, 5'h02},
            '{10'h000, 10'h000, 1'h0, 5'h06, 11'h000, 5'h02},
            '{10'h002, 10'h000, 1'h1, 5'h02, 11'h080, 5'h02},
            '{10'h082, 10'h000, 1'h1, 5'h02, 11'h180, 5'h02},
            '{10'h102, 10'h000, 1'h1, 5'h02, 11'h380, 5'h02},
            '{10'h182, 10'h000, 1'h1, 5'h02, 11'h780, 5'h02},
            '{10'h01B, 10'h000, 1'h1, 5'h02, 11'h078, 5'h02},
            '{10'h000, 10'h000, 1'h0, 5'h06, 11'h000, 5'h02},
            '{10'h004, 10'h000, 1'h1, 5'h02, 11'h001, 5'h02},
            '{10'h00C, 10'h000, 1'h1, 5'h02, 11'h004, 5'h02},
            '{10'h002, 10'h000, 1'h1, 5'h02, 11'h004, 5'h03},
            '{10'h000, 10'h000, 1'h0, 5'h10, 11'h000, 5'h03}};
        repeat (16) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        foreach (rows[i]) begin
            u_sdpr_ctrl_model.issue(rows[i].r, rows[i].f, rows[i].go, 2'h1);
            repeat (rows[i].w) @(posedge i_clk_sys);
            probe(rows[i].exp, rows[i].ill);
        end
        cmd(10'h002, 2'h1);
        cmd(10'h00B, 2'h2);
        repeat (2) @(posedge i_clk_sys);
        probe(11'h008, 5'h04);
        repeat (4) @(posedge i_clk_sys);
        cmd(10'h002, 2'h1);
        cmd(10'h00C, 2'h1);
        repeat (2) @(posedge i_clk_sys);
        probe(11'h080, 5'h05);
        @(posedge i_clk_sys);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        probe(11'h000, 5'h05);
        @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        cmd(10'h00C, 2'h1);
        ce <= 1'b0;
        repeat (20) @(posedge i_clk_sys);
        ce <= 1'b1;
        repeat (10) @(posedge i_clk_sys);
        probe(11'h004, 5'h05);
        complete_run();
    end
endmodule
bind sdpr_timing sdpr_timing_chk u_sdpr_timing_chk (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_ce(i_ce), .i_cs_n(i_cs_n), .i_ca_r(i_ca_r), .i_ca_f(i_ca_f), .o_bank_open(o_bank_open),
    .o_bank_precharging(o_bank_precharging), .o_refresh_busy(o_refresh_busy),
    .o_bank_count(o_bank_count), .o_cmd_illegal(o_cmd_illegal));
`default_nettype wire
